// File: inc/tirq_pkg.sv
// package: register map, field positions and reset values of the timer interrupt block
package tirq_pkg;

    localparam int unsigned CHANNELS        = 6;
    localparam int unsigned COUNTER_WIDTH   = 16;
    localparam int unsigned MATCH_UNITS     = 4;

    // byte offsets on the register bus
    localparam logic [7:0]  ENABLE_BASE     = 8'h00;
    localparam logic [7:0]  STATUS_BASE     = 8'h20;
    localparam logic [7:0]  EVENT_STATUS    = 8'h40;
    localparam logic [7:0]  EVENT_ENABLE    = 8'h44;
    localparam logic [7:0]  EVENT_CLEAR     = 8'h48;

    // bit positions shared by the enable and status registers
    localparam int unsigned BIT_DIRECTION   = 7;
    localparam int unsigned BIT_RESERVED6   = 6;
    localparam int unsigned BIT_UNDERFLOW   = 5;
    localparam int unsigned BIT_OVERFLOW    = 4;
    localparam int unsigned BIT_MATCH_D     = 3;
    localparam int unsigned BIT_MATCH_C     = 2;
    localparam int unsigned BIT_MATCH_B     = 1;
    localparam int unsigned BIT_MATCH_A     = 0;

    // implemented bits per channel class
    localparam logic [7:0]  FLAG_MASK_FULL  = 8'h1f;
    localparam logic [7:0]  FLAG_MASK_PHASE = 8'h33;
    localparam logic [7:0]  EN_MASK_FULL    = 8'h9f;
    localparam logic [7:0]  EN_MASK_PHASE   = 8'hb3;
    localparam logic [7:0]  READ_ONE_FULL   = 8'hc0;
    localparam logic [7:0]  READ_ONE_PHASE  = 8'h40;

    // values after reset, and the counter wrap limits
    localparam logic [7:0]  ENABLE_RESET    = 8'h00;
    localparam logic [7:0]  FLAG_RESET      = 8'h00;
    localparam logic [5:0]  EVENT_RESET     = 6'h00;
    localparam logic [15:0] COUNTER_RESET   = 16'h0000;
    localparam logic [15:0] COUNTER_MAX     = 16'hffff;
    localparam logic [15:0] COUNTER_MIN     = 16'h0000;

    // bus response codes
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0]
    {
        TIRQ_IDLE = 3'h1,
        TIRQ_FILL = 3'h2,
        TIRQ_RESP = 3'h4
    } tirq_wstate_type;

endpackage

// File: core/tirq_top.sv
// timer channel interrupt enables, status flags and register slave
//
// Overview of operation
// - overflow request active only while bit 4 enable and overflow flag set
// - underflow request raised while underflow enable and underflow flag both set
// - underflow enable at bit 5, only channels 1,2,4,5; else reads 0
// - enable bit 3 gates match D request in channels 0,3 only
// - enable bit 2 gates match C request in channels 0,3 only
// - enable bit 1 gates match B request in every channel
// - enable bit 0 gates match A request in every channel
// - match flag set on counter equal in compare, or capture load
// - each channel has its own readable 8-bit status register
// - status bit 7 shows count direction in channels 1,2,4,5
// - status bit 7 reads 1 in channels 0 and 3
// - status bit 6 reads 1 everywhere, writes ignored
// - underflow flag set on wrap from minimum to maximum in phase mode
// - status bit 5 reads 0 in channels 0 and 3
// - underflow flag cleared only by reading 1 then writing 0
// - overflow flag set when counter wraps from maximum to zero
// - overflow flag cleared only by reading 1 then writing 0
// - flags accept only written 0; writing cannot set a flag
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module tirq_top
    import tirq_pkg::*;
(
    input  wire logic                                   clock,
    input  wire logic                                   sys_rst,
    input  wire logic [tirq_pkg::CHANNELS-1:0][15:0]    channel_counter,
    input  wire logic [tirq_pkg::CHANNELS-1:0]          count_up,
    input  wire logic [tirq_pkg::CHANNELS-1:0]          phase_mode,
    input  wire logic [tirq_pkg::CHANNELS-1:0][3:0][15:0] general_reg,
    input  wire logic [tirq_pkg::CHANNELS-1:0][3:0]     compare_mode,
    input  wire logic [tirq_pkg::CHANNELS-1:0][3:0]     capture_load,
    input  wire logic [7:0]                             s_axi_awaddr,
    input  wire logic                                   s_axi_awvalid,
    output logic                                        s_axi_awready,
    input  wire logic [31:0]                            s_axi_wdata,
    input  wire logic [3:0]                             s_axi_wstrb,
    input  wire logic                                   s_axi_wvalid,
    output logic                                        s_axi_wready,
    output logic [1:0]                                  s_axi_bresp,
    output logic                                        s_axi_bvalid,
    input  wire logic                                   s_axi_bready,
    input  wire logic [7:0]                             s_axi_araddr,
    input  wire logic                                   s_axi_arvalid,
    output logic                                        s_axi_arready,
    output logic [31:0]                                 s_axi_rdata,
    output logic [1:0]                                  s_axi_rresp,
    output logic                                        s_axi_rvalid,
    input  wire logic                                   s_axi_rready,
    output logic [tirq_pkg::CHANNELS-1:0]               overflow_irq_request,
    output logic [tirq_pkg::CHANNELS-1:0]               underflow_irq_request,
    output logic [tirq_pkg::CHANNELS-1:0]               match_d_irq_request,
    output logic [tirq_pkg::CHANNELS-1:0]               match_c_irq_request,
    output logic [tirq_pkg::CHANNELS-1:0]               match_b_irq_request,
    output logic [tirq_pkg::CHANNELS-1:0]               match_a_irq_request,
    output logic                                        irq
);

    // channels 0 and 3 carry all four match units
    function automatic logic full_channel(input int unsigned ch);
        full_channel = (ch == 0) || (ch == 3);
    endfunction

    function automatic logic [7:0] flag_mask(input int unsigned ch);
        flag_mask = full_channel(ch) ? FLAG_MASK_FULL : FLAG_MASK_PHASE;
    endfunction

    function automatic logic [7:0] enable_mask(input int unsigned ch);
        enable_mask = full_channel(ch) ? EN_MASK_FULL : EN_MASK_PHASE;
    endfunction

    // register decode: returns channel index, valid when in range
    function automatic logic decode_channel(input logic [7:0] addr, input logic [7:0] base,
                                            output logic [2:0] ch);
        logic [7:0] rel;
        rel = addr - base;
        ch  = rel[4:2];
        decode_channel = (addr >= base) && (rel[7:5] == 3'h0) && (rel[1:0] == 2'h0)
                         && (rel[4:2] < 3'(CHANNELS));
    endfunction

    // state
    logic [CHANNELS-1:0][7:0]   enable_reg;
    logic [CHANNELS-1:0][7:0]   next_enable_reg;
    logic [CHANNELS-1:0][7:0]   flag_reg;
    logic [CHANNELS-1:0][7:0]   next_flag_reg;
    logic [CHANNELS-1:0][7:0]   armed;
    logic [CHANNELS-1:0][7:0]   next_armed;
    logic [CHANNELS-1:0][15:0]  counter_prev;
    logic [CHANNELS-1:0]        counter_seen;
    logic [CHANNELS-1:0][7:0]   set_event;
    logic [5:0]                 event_status;
    logic [5:0]                 next_event_status;
    logic [5:0]                 event_enable;
    logic [5:0]                 next_event_enable;

    // bus state
    tirq_wstate_type            wstate;
    tirq_wstate_type            next_wstate;
    logic [7:0]                 waddr;
    logic [7:0]                 next_waddr;
    logic [7:0]                 wbyte;
    logic [7:0]                 next_wbyte;
    logic                       wbyte_en;
    logic                       next_wbyte_en;
    logic                       aw_held;
    logic                       next_aw_held;
    logic                       w_held;
    logic                       next_w_held;
    logic                       next_awready;
    logic                       next_wready;
    logic                       next_bvalid;
    logic [1:0]                 next_bresp;
    logic                       next_arready;
    logic                       next_rvalid;
    logic [31:0]                next_rdata;
    logic [1:0]                 next_rresp;
    logic                       do_write;
    logic                       do_read;

    // per-channel event detection from the counter
    genvar gch;
    genvar gu;
    generate
        for (gch = 0; gch < CHANNELS; gch++)
        begin : g_event
            logic moved;
            assign moved = counter_seen[gch] && (channel_counter[gch] != counter_prev[gch]);
            // overflow wrap
            assign set_event[gch][BIT_OVERFLOW] = counter_seen[gch]
                && (counter_prev[gch] == COUNTER_MAX) && (channel_counter[gch] == COUNTER_MIN);
            // underflow wrap
            if (full_channel(gch))
            begin : g_nounder
                assign set_event[gch][BIT_UNDERFLOW] = 1'b0;
            end
            else
            begin : g_under
                assign set_event[gch][BIT_UNDERFLOW] = phase_mode[gch] && counter_seen[gch]
                    && (counter_prev[gch] == COUNTER_MIN) && (channel_counter[gch] == COUNTER_MAX);
            end
            // compare match or capture
            for (gu = 0; gu < MATCH_UNITS; gu++)
            begin : g_match
                assign set_event[gch][gu] = (full_channel(gch) || gu <= BIT_MATCH_B) && (capture_load[gch][gu]
                    || (compare_mode[gch][gu] && moved && channel_counter[gch] == general_reg[gch][gu]));
            end
            assign set_event[gch][7:6] = 2'b00;
        end
    endgenerate

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            counter_prev <= '{default: COUNTER_RESET};
            counter_seen <= '0;
        end
        else
        begin
            counter_prev <= channel_counter;
            counter_seen <= '1;
        end
    end

    // write channel: address and data taken in either order
    always_comb
    begin
        next_wstate   = wstate;
        next_waddr    = waddr;
        next_wbyte    = wbyte;
        next_wbyte_en = wbyte_en;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_awready  = s_axi_awready;
        next_wready   = s_axi_wready;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        do_write      = 1'b0;
        case (wstate)
            TIRQ_IDLE, TIRQ_FILL:
            begin
                if (s_axi_awvalid && s_axi_awready)
                begin
                    next_waddr   = s_axi_awaddr;
                    next_aw_held = 1'b1;
                    next_awready = 1'b0;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    next_wbyte    = s_axi_wdata[7:0];
                    next_wbyte_en = s_axi_wstrb[0];
                    next_w_held   = 1'b1;
                    next_wready   = 1'b0;
                end
                if (aw_held && w_held)
                begin
                    do_write     = 1'b1;
                    next_bvalid  = 1'b1;
                    next_bresp   = write_ok(waddr) ? RESP_OKAY : RESP_SLVERR;
                    next_aw_held = 1'b0;
                    next_w_held  = 1'b0;
                    next_wstate  = TIRQ_RESP;
                end
                else if (next_aw_held || next_w_held)
                begin
                    next_wstate = TIRQ_FILL;
                end
            end
            TIRQ_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_bvalid  = 1'b0;
                    next_awready = 1'b1;
                    next_wready  = 1'b1;
                    next_wstate  = TIRQ_IDLE;
                end
            end
            default:
            begin
                next_wstate  = TIRQ_IDLE;
                next_awready = 1'b1;
                next_wready  = 1'b1;
                next_bvalid  = 1'b0;
            end
        endcase
    end

    function automatic logic write_ok(input logic [7:0] addr);
        logic [2:0] ch;
        write_ok = decode_channel(addr, ENABLE_BASE, ch) || decode_channel(addr, STATUS_BASE, ch)
                   || addr == EVENT_STATUS || addr == EVENT_ENABLE || addr == EVENT_CLEAR;
    endfunction

    // read channel: one read at a time, answer one cycle after the address
    assign do_read = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        logic [2:0] ch;
        ch           = 3'h0;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (do_read)
        begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rdata   = 32'h0000_0000;
            next_rresp   = RESP_OKAY;
            if (decode_channel(s_axi_araddr, ENABLE_BASE, ch))
                next_rdata[7:0] = enable_view(ch);
            // per-channel status view
            // status readback
            else if (decode_channel(s_axi_araddr, STATUS_BASE, ch))
                next_rdata[7:0] = status_view(ch);
            else if (s_axi_araddr == EVENT_STATUS)
                next_rdata[5:0] = event_status;
            else if (s_axi_araddr == EVENT_ENABLE)
                next_rdata[5:0] = event_enable;
            else if (s_axi_araddr != EVENT_CLEAR)
                next_rresp = RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    function automatic logic [7:0] enable_view(input logic [2:0] ch);
        // unimplemented bits read 0; bit 6 reads 1
        enable_view = (enable_reg[ch] & enable_mask(ch)) | READ_ONE_PHASE;
    endfunction

    function automatic logic [7:0] status_view(input logic [2:0] ch);
        logic [7:0] v;
        v = (flag_reg[ch] & flag_mask(ch)) | (full_channel(ch) ? READ_ONE_FULL : READ_ONE_PHASE);
        if (!full_channel(ch))
            v[BIT_DIRECTION] = count_up[ch];
        status_view = v;
    endfunction

    // enables, flags, arming and the summary interrupt
    always_comb
    begin
        logic [2:0] wch;
        logic [2:0] rch;
        logic       wr_en;
        logic       wr_st;
        logic       rd_st;
        logic [7:0] clr;
        wch   = 3'h0;
        rch   = 3'h0;
        clr   = 8'h00;
        wr_en = do_write && wbyte_en && decode_channel(waddr, ENABLE_BASE, wch);
        wr_st = do_write && wbyte_en && decode_channel(waddr, STATUS_BASE, wch);
        rd_st = do_read && decode_channel(s_axi_araddr, STATUS_BASE, rch);
        next_enable_reg   = enable_reg;
        next_flag_reg     = flag_reg;
        next_armed        = armed;
        next_event_status = event_status;
        next_event_enable = event_enable;
        // only implemented enable bits take writes
        if (wr_en)
            next_enable_reg[wch] = wbyte & enable_mask(wch);
        if (rd_st)
            next_armed[rch] = armed[rch] | (flag_reg[rch] & flag_mask(rch));
        // only armed bits written 0 clear; ones never set
        if (wr_st)
        begin
            clr             = armed[wch] & ~wbyte;
            next_flag_reg[wch] = flag_reg[wch] & ~clr;
            next_armed[wch]    = 8'h00;
        end
        if (do_write && wbyte_en && waddr == EVENT_ENABLE)
            next_event_enable = wbyte[5:0];
        if (do_write && wbyte_en && waddr == EVENT_CLEAR)
            next_event_status = event_status & ~wbyte[5:0];
        for (int c = 0; c < CHANNELS; c++)
        begin
            // events set, winning over a clear
            next_flag_reg[c] = (next_flag_reg[c] | set_event[c]) & flag_mask(c);
            if ((set_event[c] & ~flag_reg[c]) != 8'h00)
                next_event_status[c] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wstate        <= TIRQ_IDLE;
            waddr         <= 8'h00;
            wbyte         <= 8'h00;
            wbyte_en      <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            wstate        <= next_wstate;
            waddr         <= next_waddr;
            wbyte         <= next_wbyte;
            wbyte_en      <= next_wbyte_en;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            enable_reg   <= '{default: ENABLE_RESET};
            flag_reg     <= '{default: FLAG_RESET};
            armed        <= '{default: FLAG_RESET};
            event_status <= EVENT_RESET;
            event_enable <= EVENT_RESET;
        end
        else
        begin
            enable_reg   <= next_enable_reg;
            flag_reg     <= next_flag_reg;
            armed        <= next_armed;
            event_status <= next_event_status;
            event_enable <= next_event_enable;
        end
    end

    // interrupt requests registered from flags and enables
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            overflow_irq_request  <= '0;
            underflow_irq_request <= '0;
            match_d_irq_request   <= '0;
            match_c_irq_request   <= '0;
            match_b_irq_request   <= '0;
            match_a_irq_request   <= '0;
            irq                   <= 1'b0;
        end
        else
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                overflow_irq_request[c]  <= next_flag_reg[c][BIT_OVERFLOW] && next_enable_reg[c][BIT_OVERFLOW];
                underflow_irq_request[c] <= next_flag_reg[c][BIT_UNDERFLOW] && next_enable_reg[c][BIT_UNDERFLOW];
                match_d_irq_request[c]   <= next_flag_reg[c][BIT_MATCH_D] && next_enable_reg[c][BIT_MATCH_D];
                match_c_irq_request[c]   <= next_flag_reg[c][BIT_MATCH_C] && next_enable_reg[c][BIT_MATCH_C];
                match_b_irq_request[c]   <= next_flag_reg[c][BIT_MATCH_B] && next_enable_reg[c][BIT_MATCH_B];
                match_a_irq_request[c]   <= next_flag_reg[c][BIT_MATCH_A] && next_enable_reg[c][BIT_MATCH_A];
            end
            irq <= (next_event_status & next_event_enable) != 6'h00;
        end
    end

endmodule

// File: verification/tirq_chk.sv
// checker: bus timing and request gating at the tirq_top ports
`timescale 1ns/1ns
module tirq_chk
(
    input wire logic             clock,
    input wire logic             sys_rst,
    input wire logic [5:0][15:0] channel_counter,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [5:0]       overflow_irq_request,
    input wire logic [5:0]       underflow_irq_request,
    input wire logic [5:0]       match_d_irq_request,
    input wire logic [5:0]       match_c_irq_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    for (genvar k = 0; k < 6; k++)
    begin : g_ovf
        AST_OVF_CAUSE: assert property ($rose(overflow_irq_request[k]) |-> $rose(s_axi_bvalid) ||
            ($past(channel_counter[k]) == 16'h0000 && $past(channel_counter[k], 2) == 16'hffff))
            else $error("overflow request without wrap or write");
    end
    AST_NO_UNF: assert property ((underflow_irq_request & 6'h09) == 6'h00)
        else $error("underflow request on channel 0 or 3");
    AST_NO_D: assert property ((match_d_irq_request & 6'h36) == 6'h00)
        else $error("match d request on a phase channel");
    AST_NO_C: assert property ((match_c_irq_request & 6'h36) == 6'h00)
        else $error("match c request on a phase channel");
    AST_RDATA: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above byte 0");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not released");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not released");
endmodule
bind tirq_top tirq_chk u_chk (.clock, .sys_rst, .channel_counter, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .overflow_irq_request, .underflow_irq_request,
    .match_d_irq_request, .match_c_irq_request);

// File: verification/tirq_intc_model.sv
// interrupt controller model: counts rising interrupt levels
`timescale 1ns/1ns
module tirq_intc_model
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       irq,
    output logic [7:0]      taken
);
    logic irq_q;
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            {taken, irq_q} <= 9'h000;
        else
            {taken, irq_q} <= {taken + {7'h00, irq && !irq_q}, irq};
    end
endmodule

// File: verification/timer_irq_enable_status_tb.sv
// testbench: register access, flag events and interrupt gating
`timescale 1ns/1ns
module timer_irq_enable_status_tb;
    import tirq_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, irq;
    logic [5:0][15:0] channel_counter = '0;
    logic [5:0][3:0][15:0] general_reg = '0;
    logic [5:0][3:0] compare_mode = '0, capture_load = '0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, taken;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [5:0] count_up = 6'h12, phase_mode = 6'h3f, ovf, unf, md, mc, mb, ma;
    logic [3:0] s_axi_wstrb = 4'hf;
    int miscompares = 0, checks = 0, cycles = 0;
    tirq_top DUT (.clock, .sys_rst, .channel_counter, .count_up, .phase_mode, .general_reg, .compare_mode,
        .capture_load, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .overflow_irq_request(ovf), .underflow_irq_request(unf), .match_d_irq_request(md),
        .match_c_irq_request(mc), .match_b_irq_request(mb), .match_a_irq_request(ma), .irq);
    tirq_intc_model u_intc (.clock, .sys_rst, .irq, .taken);
    always #25 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic setc(input logic [15:0] v);
        @(posedge clock);
        channel_counter <= {6{v}};
    endtask
    function automatic logic [7:0] ea(int c);
        return ENABLE_BASE + 8'(4 * c);
    endfunction
    function automatic logic [7:0] sa(int c);
        return STATUS_BASE + 8'(4 * c);
    endfunction
    function automatic logic [31:0] base(int c);
        return (c % 3 == 0) ? 32'hc0 : {24'h0, count_up[c], 7'h40};
    endfunction
    task automatic clear_all();
        for (int c = 0; c < 6; c++)
        begin
            rd(sa(c));
            wr(sa(c), 8'h00);
        end
    endtask
    initial
    begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        for (int c = 0; c < 6; c++)
        begin
            rd(ea(c));
            chk(rv, 32'h40);
            rd(sa(c));
            chk(rv, base(c));
            wr(ea(c), 8'hff);
            wr(sa(c), 8'hff);
            chk(32'(resp), 32'(RESP_OKAY));
            rd(ea(c));
            chk(rv, (c % 3 == 0) ? 32'hdf : 32'hf3);
            rd(sa(c));
            chk(rv, base(c));
        end
        wr(EVENT_ENABLE, 8'h3f);
        setc(16'hffff);
        setc(16'h0000);
        repeat (2) @(posedge clock);
        chk(32'(ovf), 32'h3f);
        chk(32'(unf), 32'h36);
        rd(EVENT_STATUS);
        chk({rv[30:0], irq}, 32'h7f);
        wr(EVENT_CLEAR, 8'h3f);
        chk(32'(irq), 32'h0);
        for (int c = 0; c < 6; c++)
        begin
            wr(sa(c), 8'h00);
            rd(sa(c));
            chk(rv, base(c) | ((c % 3 == 0) ? 32'h10 : 32'h30));
            wr(sa(c), 8'h00);
            rd(sa(c));
            chk(rv, base(c));
        end
        chk(32'({ovf, unf}), 32'h0);
        for (int c = 0; c < 6; c++)
            wr(ea(c), 8'h00);
        setc(16'hffff);
        setc(16'h0000);
        repeat (2) @(posedge clock);
        chk(32'({ovf, unf}), 32'h0);
        for (int c = 0; c < 6; c++)
            wr(ea(c), 8'hff);
        chk(32'({ovf, unf}), 32'hff6);
        for (int m = 0; m < 2; m++)
        begin
            clear_all();
            chk(32'({ma, mb, mc, md, ovf}), 32'h0);
            if (m == 0)
            begin
                compare_mode <= '1;
                general_reg <= {24{16'h1234}};
                setc(16'h1234);
            end
            else
            begin
                capture_load <= '1;
                @(posedge clock);
                capture_load <= '0;
            end
            repeat (2) @(posedge clock);
            chk(32'({ma, mb, mc, md}), 32'(24'hfff249));
        end
        phase_mode <= 6'h00;
        setc(16'h0000);
        setc(16'hffff);
        repeat (2) @(posedge clock);
        chk(32'(unf), 32'h0);
        rd(8'h80);
        chk({rv[29:0], resp}, 32'(RESP_SLVERR));
        wr(8'h80, 8'h00);
        chk(32'(resp), 32'(RESP_SLVERR));
        chk(32'(taken), 32'h2);
        give_verdict();
    end
endmodule
